/* File: core/cmd_cap_regs.sv */
/*
  Enhanced command capability register bank with an APB slave.
  Assumes one clock (pclk), asynchronous active-low reset, and a straps input that
  comes from a static configuration source outside the clock domain.
*/
// Functional notes
// R1 - The register for command codes 64 to 127 sits at 438h and reads all zero.
// R2 - The register for command codes 128 to 191 sits at 440h and reads all zero.
// R3 - The register for command codes 192 to 255 sits at 448h.
// R4 - Without enhanced command support every one of these registers reads zero and ignores writes.
// R5 - Bit 53 of the top register shows whether the unfreeze-all-counters command exists.
// R6 - Bit 52 of the top register shows whether the freeze-all-counters command exists.
// R7 - Bit 51 of the top register shows whether the clear-all-counter-values command exists.
// R8 - Bit 50 of the top register shows whether the reset-all-counter-configuration command exists.
// R9 - Bit 49 of the top register shows whether the disable-one-counter command exists.
// R10 - Bit 48 of the top register shows whether the enable-one-counter command exists.
// R11 - A command reported unsupported completes with status code 1, undefined command.
// R12 - Capability bits are fixed read-only values; reserved bits read zero and writes are ignored.
// R13 - Flag bits 48 to 53 map to command codes 240 to 245, position equals code minus 192.
`timescale 1ns/1ps
module cmd_cap_regs
  import cmd_cap_pkg::*;
#(
  parameter logic [FLAG_COUNT-1:0] SUPPORTED = 6'h3F
)(
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  clk_en,
  input  wire logic                  extended_command_present,
  input  wire apb_req_t              apb_req,
  output apb_rsp_t                   apb_rsp,
  output logic [FLAG_COUNT-1:0]      support_flags
);

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_ACCESS = 2'b01
  } bus_state_t;

  bus_state_t            state;
  logic [2:0]            present_sync;
  logic                  present;
  logic [FLAG_COUNT-1:0] flags;
  logic [7:0]            check_code;
  logic [6:0]            check_status;
  logic [31:0]           next_rdata;
  logic                  next_err;
  logic                  hit;
  logic [31:0]           prdata;
  logic                  pslverr;
  logic [31:0]           top_hi_word;
  logic                  setup_taken;

  // Strap passes three flops; it counts once the second and third agree
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      present_sync <= 3'h0;
    else if (clk_en)
      present_sync <= {present_sync[1:0], extended_command_present};
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      present <= 1'b0;
    else if (clk_en && (present_sync[1] == present_sync[2]))
      present <= present_sync[2];
  end

  // Flags are masked to zero when the whole set is absent
  always_comb
  begin
    flags = present ? SUPPORTED : '0; // R4 R12
  end
  assign support_flags = flags;

  // Access phase state
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state <= ST_IDLE;
    else if (clk_en)
    begin
      case (state)
        ST_IDLE:   state <= (apb_req.psel && !apb_req.penable) ? ST_ACCESS : ST_IDLE;
        ST_ACCESS: state <= ST_IDLE;
        default:   state <= ST_IDLE;
      endcase
    end
  end

  // Setup cycle accepted at this edge
  assign setup_taken = clk_en && state == ST_IDLE && apb_req.psel && !apb_req.penable;

  // Each flag lands at its own bit of the top high word; the rest stays zero
  genvar g;
  generate
    for (g = 0; g < 32; g++)
    begin : g_top_bit
      if (g >= FLAG_LSB_HI_WORD && g < FLAG_LSB_HI_WORD + FLAG_COUNT)
      begin : g_flag
        assign top_hi_word[g] = flags[g - FLAG_LSB_HI_WORD]; // R13
      end
      else
      begin : g_rsvd
        assign top_hi_word[g] = 1'b0; // R12
      end
    end
  endgenerate

  // Read decode; writes to capability words are dropped
  always_comb
  begin
    next_rdata = WORD_ZERO;
    next_err   = 1'b0;
    hit        = 1'b1;
    case (apb_req.paddr)
      OFF_MID_LOW_LO, OFF_MID_LOW_HI:   next_rdata = WORD_ZERO; // R1
      OFF_MID_HIGH_LO, OFF_MID_HIGH_HI: next_rdata = WORD_ZERO; // R2
      OFF_TOP_LO:                       next_rdata = WORD_ZERO; // R3 R12
      OFF_TOP_HI:                       next_rdata = top_hi_word; // R3 R5 R6 R7 R8 R9 R10 R13
      OFF_CTRL:                         next_rdata = {24'h0, check_status, present};
      OFF_CHECK:                        next_rdata = {24'h0, check_code};
      default:
      begin
        hit      = 1'b0;
        next_err = 1'b1;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= WORD_ZERO;
      pslverr <= 1'b0;
    end
    else if (clk_en && state == ST_IDLE && apb_req.psel && !apb_req.penable)
    begin
      prdata  <= apb_req.pwrite ? WORD_ZERO : next_rdata;
      pslverr <= next_err;
    end
  end

  // Command probe: software writes a code, hardware reports the status it would get
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      check_code   <= CODE_RESET;
      check_status <= STATUS_UNDEFINED;
    end
    else if (clk_en)
    begin
      if (state == ST_ACCESS && apb_req.psel && apb_req.penable && apb_req.pwrite
          && apb_req.paddr == OFF_CHECK)
        check_code <= apb_req.pwdata[7:0];
      check_status <= code_ok(check_code) ? STATUS_OK : STATUS_UNDEFINED; // R11
    end
  end

  function automatic logic code_ok(input logic [7:0] code);
    logic [7:0] pos;
    pos = code - CODE_ENABLE_ONE;
    code_ok = (code >= CODE_ENABLE_ONE) && (pos < 8'(FLAG_COUNT)) && flags[pos[2:0]]; // R13
  endfunction : code_ok

  // One driver for the whole response struct
  assign apb_rsp = '{
    pready:  (state == ST_ACCESS),
    pslverr: pslverr && (state == ST_ACCESS),
    prdata:  prdata
  };

  // Checks

  AST_MID_ZERO: assert property (@(posedge pclk) disable iff (!presetn) // R1
    (clk_en && state == ST_IDLE && apb_req.psel && !apb_req.penable && !apb_req.pwrite
     && apb_req.paddr[11:4] == 8'h43 && apb_req.paddr[3]) ##1 apb_rsp.pready |-> apb_rsp.prdata == WORD_ZERO)
    else $error("mid_low word not zero");
  AST_MIDHI_ZERO: assert property (@(posedge pclk) disable iff (!presetn) // R2
    (clk_en && state == ST_IDLE && apb_req.psel && !apb_req.penable && apb_req.paddr == OFF_MID_HIGH_HI)
    |=> apb_rsp.prdata == WORD_ZERO)
    else $error("mid_high word not zero");
  AST_TOP_READ: assert property (@(posedge pclk) disable iff (!presetn) // R3
    (clk_en && state == ST_IDLE && apb_req.psel && !apb_req.penable && !apb_req.pwrite
     && apb_req.paddr == OFF_TOP_HI) |=> apb_rsp.prdata[21:16] == $past(flags))
    else $error("top word does not show flags");
  AST_ABSENT: assert property (@(posedge pclk) disable iff (!presetn) // R4
    !present |-> support_flags == '0)
    else $error("flags visible without support");
  AST_THAW: assert property (@(posedge pclk) disable iff (!presetn) // R5
    present |-> support_flags[BIT_THAW_ALL-BIT_ENABLE_ONE] == SUPPORTED[5])
    else $error("thaw flag wrong");
  AST_HALT: assert property (@(posedge pclk) disable iff (!presetn) // R6
    present |-> support_flags[BIT_HALT_ALL-BIT_ENABLE_ONE] == SUPPORTED[4])
    else $error("halt flag wrong");
  AST_RSVD: assert property (@(posedge pclk) disable iff (!presetn) // R12
    apb_rsp.pready && $past(apb_req.paddr == OFF_TOP_HI) |-> apb_rsp.prdata[31:22] == 10'h0
      && apb_rsp.prdata[15:0] == 16'h0)
    else $error("reserved bits set");
  AST_UNDEF: assert property (@(posedge pclk) disable iff (!presetn) // R11
    clk_en && !present ##1 clk_en |-> check_status == STATUS_UNDEFINED)
    else $error("unsupported command not undefined");
  AST_STABLE: assert property (@(posedge pclk) disable iff (!presetn) // R12
    $stable(present) |-> $stable(support_flags))
    else $error("capability changed by access");

  AST_CLEAR_VALUES: assert property (@(posedge pclk) disable iff (!presetn) // R7
    present
    |->
    support_flags[BIT_CLEAR_VALUES-BIT_ENABLE_ONE] == SUPPORTED[3])
    else $error("clear values flag wrong");

  AST_CLEAR_SETUP: assert property (@(posedge pclk) disable iff (!presetn) // R8
    present
    |->
    support_flags[BIT_CLEAR_SETUP-BIT_ENABLE_ONE] == SUPPORTED[2])
    else $error("clear setup flag wrong");

  AST_DISABLE_ONE: assert property (@(posedge pclk) disable iff (!presetn) // R9
    present
    |->
    support_flags[BIT_DISABLE_ONE-BIT_ENABLE_ONE] == SUPPORTED[1])
    else $error("disable one flag wrong");

  AST_ENABLE_ONE: assert property (@(posedge pclk) disable iff (!presetn) // R10
    present
    |->
    support_flags[0] == SUPPORTED[0])
    else $error("enable one flag wrong");

  AST_TOP_LOW_ZERO: assert property (@(posedge pclk) disable iff (!presetn) // R3
    setup_taken && !apb_req.pwrite && apb_req.paddr == OFF_TOP_LO
    |=>
    apb_rsp.prdata == WORD_ZERO)
    else $error("top low word not zero");

  AST_PROBE_OK: assert property (@(posedge pclk) disable iff (!presetn) // R11
    clk_en && present && check_code >= CODE_ENABLE_ONE && check_code < CODE_ENABLE_ONE + 8'(FLAG_COUNT)
    && SUPPORTED[check_code[2:0]] ##1 clk_en
    |->
    check_status == STATUS_OK)
    else $error("supported command not reported ok");

  AST_PROBE_OUTSIDE: assert property (@(posedge pclk) disable iff (!presetn) // R11
    clk_en && (check_code < CODE_ENABLE_ONE || check_code >= CODE_ENABLE_ONE + 8'(FLAG_COUNT)) ##1 clk_en
    |->
    check_status == STATUS_UNDEFINED)
    else $error("code outside the flags not undefined");

  AST_CTRL_LAYOUT: assert property (@(posedge pclk) disable iff (!presetn) // R11
    setup_taken && !apb_req.pwrite && apb_req.paddr == OFF_CTRL
    |=>
    apb_rsp.prdata[7:1] == $past(check_status) && apb_rsp.prdata[0] == $past(present))
    else $error("status word layout wrong");

  AST_WRITE_DROPPED: assert property (@(posedge pclk) disable iff (!presetn) // R12
    setup_taken && apb_req.pwrite && apb_req.paddr >= OFF_MID_LOW_LO && apb_req.paddr <= OFF_TOP_HI
    |=>
    apb_rsp.prdata == WORD_ZERO && !apb_rsp.pslverr)
    else $error("write to capability word had an effect");

  AST_UNMAPPED_ERR: assert property (@(posedge pclk) disable iff (!presetn)
    setup_taken && !hit
    |=>
    apb_rsp.pready && apb_rsp.pslverr)
    else $error("unmapped word without error");

  AST_READY_ONE: assert property (@(posedge pclk) disable iff (!presetn)
    apb_rsp.pready && clk_en
    |=>
    !apb_rsp.pready)
    else $error("ready held past one cycle");

  AST_FREEZE: assert property (@(posedge pclk) disable iff (!presetn)
    !clk_en
    |=>
    $stable(state) && $stable(present) && $stable(check_code) && $stable(check_status))
    else $error("state moved while clock enable low");

  AST_FREEZE_DATA: assert property (@(posedge pclk) disable iff (!presetn)
    !clk_en
    |=>
    $stable(apb_rsp.prdata))
    else $error("read data moved while clock enable low");

  // Every flag follows its own supported bit
  generate
    for (g = 0; g < FLAG_COUNT; g++)
    begin : g_flag_check
      AST_FLAG_BIT: assert property (@(posedge pclk) disable iff (!presetn) // R13
        support_flags[g] == (present && SUPPORTED[g]))
        else $error("flag bit does not follow its code");
    end
  endgenerate

endmodule : cmd_cap_regs

/* File: core/cmd_cap_pkg.sv */
/*
  Package for the enhanced command capability register bank: offsets, field positions,
  command codes, status codes and the carrier structs of the APB slave.
  Assumes a 32-bit APB with byte addresses; each 64-bit register spans two words.
*/
package cmd_cap_pkg;

  localparam int          ADDR_W            = 12;
  localparam int          DATA_W            = 32;

  // Capability registers, low word at the offset, high word four bytes above
  localparam logic [11:0] OFF_MID_LOW_LO    = 12'h438;
  localparam logic [11:0] OFF_MID_LOW_HI    = 12'h43C;
  localparam logic [11:0] OFF_MID_HIGH_LO   = 12'h440;
  localparam logic [11:0] OFF_MID_HIGH_HI   = 12'h444;
  localparam logic [11:0] OFF_TOP_LO        = 12'h448;
  localparam logic [11:0] OFF_TOP_HI        = 12'h44C;
  // Local control/status words
  localparam logic [11:0] OFF_CTRL          = 12'h450;
  localparam logic [11:0] OFF_CHECK         = 12'h454;

  // Flag positions inside the top register (64-bit numbering)
  localparam int          BIT_ENABLE_ONE    = 48;
  localparam int          BIT_DISABLE_ONE   = 49;
  localparam int          BIT_CLEAR_SETUP   = 50;
  localparam int          BIT_CLEAR_VALUES  = 51;
  localparam int          BIT_HALT_ALL      = 52;
  localparam int          BIT_THAW_ALL      = 53;
  localparam int          FLAG_COUNT        = 6;
  localparam int          FLAG_LSB_HI_WORD  = BIT_ENABLE_ONE - 32;

  // Command codes covered by the top register start here
  localparam logic [7:0]  TOP_CODE_BASE     = 8'hC0;
  localparam logic [7:0]  CODE_ENABLE_ONE   = 8'hF0;

  localparam logic [6:0]  STATUS_OK         = 7'h00;
  localparam logic [6:0]  STATUS_UNDEFINED  = 7'h01;

  localparam logic [31:0] WORD_ZERO         = 32'h0000_0000;
  localparam logic [7:0]  CODE_RESET        = 8'h00;

  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic              pready;
    logic              pslverr;
    logic [DATA_W-1:0] prdata;
  } apb_rsp_t;

endpackage : cmd_cap_pkg

/* File: verif/cmd_cap_regs_tb.sv */
/*
  Self-checking bench for the capability register bank: APB reads and writes,
  strap on and off, command probes and an unmapped word.
  Assumes cmd_cap_pkg is compiled first; one 125 MHz clock.
*/
`timescale 1ns/1ps
module cmd_cap_regs_tb;
  import cmd_cap_pkg::*;
  localparam logic [5:0] SUP = 6'h2D;
  logic        pclk;
  logic        presetn;
  logic        ce;
  logic        present;
  apb_req_t    req;
  apb_rsp_t    rsp;
  logic [5:0]  flags;
  logic [32:0] expq[$];
  logic [32:0] e;
  logic [7:0]  code;
  logic [6:0]  st;
  int          mismatches;
  int          n_checks;
  int          i;

  cmd_cap_regs #(.SUPPORTED(SUP)) cmd_cap_regs_inst (
    .pclk                     (pclk),
    .presetn                  (presetn),
    .clk_en                   (ce),
    .extended_command_present (present),
    .apb_req                  (req),
    .apb_rsp                  (rsp),
    .support_flags            (flags)
  );

  initial
  begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  task give_verdict;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : give_verdict

  task chk(input string nm, input logic [32:0] ex, input logic [32:0] got);
    n_checks++;
    if (ex !== got)
    begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk

  // One APB transfer; an idle cycle follows so psel is never reassigned in one step
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    req.penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (rsp.pready !== 1'b1 && n < 16);
    if (n >= 16)
    begin
      mismatches++;
      give_verdict();
    end
    req <= '0;
    @(posedge pclk);
  endtask : apb

  task rd(input logic [11:0] a, input logic [32:0] ex);
    expq.push_back(ex);
    apb(1'b0, a, 32'h0000_0000);
  endtask : rd

  // Compares each completed read with the oldest note
  always @(posedge pclk)
    if (req.psel && req.penable && !req.pwrite && rsp.pready === 1'b1)
    begin
      e = expq.pop_front();
      chk("read", e, {rsp.pslverr, rsp.prdata});
    end

  task words(input logic on);
    for (i = 0; i < 6; i++)
    begin
      apb(1'b1, 12'(OFF_MID_LOW_LO + 4 * i), $urandom());
      rd(12'(OFF_MID_LOW_LO + 4 * i), {1'b0, (i == 5 && on) ? {10'h000, SUP, 16'h0000} : 32'h0});
    end
    chk("flags", {27'h0, on ? SUP : 6'h00}, {27'h0, flags});
    for (i = 0; i < 8; i++)
    begin
      code = (i < 6) ? 8'(8'hF0 + i) : 8'hFF;
      if (i == 6)
        code = 8'($urandom_range(239, 0));
      st = (on && i < 6 && SUP[i]) ? STATUS_OK : STATUS_UNDEFINED;
      apb(1'b1, OFF_CHECK, {24'h000000, code});
      rd(OFF_CHECK, {9'h000, 16'h0000, code});
      rd(OFF_CTRL, {9'h000, 16'h0000, st, on});
    end
    rd(12'h460, {1'b1, 32'h0000_0000});
  endtask : words

  initial
  begin
    presetn = 1'b0;
    present = 1'b1;
    ce = 1'b1;
    req = '0;
    mismatches = 0;
    n_checks = 0;
    i = $urandom(3964);
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    repeat (6) @(posedge pclk);
    words(1'b1);
    // Strap drops while the clock enable is low: nothing may move
    ce <= 1'b0;
    present <= 1'b0;
    repeat (8) @(posedge pclk);
    chk("frozen flags", {27'h0, SUP}, {27'h0, flags});
    ce <= 1'b1;
    repeat (8) @(posedge pclk);
    words(1'b0);
    chk("pending reads", 33'h0, 33'(expq.size()));
    give_verdict();
  end
endmodule : cmd_cap_regs_tb
